// ==== core/rlc_level_calc.sv ====
// Ladder level numerator and divisor from the tap code and range
`timescale 1ns/10ps
`include "rlc_consts.svh"
module rlc_level_calc
  import rlc_pkg::*;
(
  // Control
  input  wire logic       range_sel,
  input  wire logic [3:0] tap_code,
  // Result: level = numer / denom of the supply span
  output logic [7:0]      level_numer,
  output logic [7:0]      level_denom
);
  always_comb begin
    if (range_sel) begin
      level_numer = {4'h0, tap_code};
      level_denom = `RLC_LOW_DIV;
    end else begin
      level_numer = `RLC_HIGH_BASE + {4'h0, tap_code};
      level_denom = `RLC_HIGH_DIV;
    end
  end
endmodule

// ==== core/rlc_pin_mux.sv ====
// Shared port pin two routing between ladder output and digital direction
`timescale 1ns/10ps
`include "rlc_consts.svh"
module rlc_pin_mux
  import rlc_pkg::*;
(
  // Control
  input  wire logic pin_drive,
  input  wire logic dir_bit,
  // Pin path
  output logic      analog_connect,
  output logic      digital_oe
);
  // The drive bit wins over the direction bit; the digital driver is cut
  always_comb begin
    analog_connect = pin_drive;
    digital_oe     = ~pin_drive & ~dir_bit;
  end
endmodule

// ==== core/rlc_top.sv ====
// Reference ladder control block with AXI4-Lite register access
`timescale 1ns/10ps
`include "rlc_consts.svh"
module rlc_top
  import rlc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Analog ladder controls
  output logic             ladder_power_on,
  output logic             ladder_range_select,
  output logic             ladder_supply_select,
  output logic [3:0]       ladder_tap_code,
  output logic             ladder_to_comparators,
  // Shared port pin two
  output logic             ref_pin_connect,
  output logic             pin_two_digital_oe
);
  rlc_ctrl_t   ctrl_q;
  logic [2:0]  cmp_mode_q;
  logic [7:0]  port_dir_q;
  logic        aw_held_q;
  logic [11:0] aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic        w_strb0_q;
  rlc_ladder_t lad_q;
  logic        pin_oe_q;
  logic [7:0]  level_numer;
  logic [7:0]  level_denom;
  logic        pin_connect_d;
  logic        pin_oe_d;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_data;
  logic        rd_hit;

  // Only these four word offsets answer OKAY; anything else is refused
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `RLC_CTRL_OFS) || (a == `RLC_CMP_MODE_OFS) ||
                 (a == `RLC_PORT_DIR_OFS) || (a == `RLC_STATUS_OFS);
  endfunction

  // Write channel: address and data are taken in either order
  assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_axi_wdata;
      w_strb0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RLC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(aw_addr_q) ? RLC_RESP_OKAY : RLC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; no sleep input exists, so waking cannot disturb it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `RLC_CTRL_RESET;
    end else if (wr_fire && w_strb0_q && aw_addr_q == `RLC_CTRL_OFS) begin
      ctrl_q <= w_data_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_mode_q <= `RLC_CMP_MODE_RESET;
      port_dir_q <= `RLC_PORT_DIR_RESET;
    end else if (wr_fire && w_strb0_q) begin
      if (aw_addr_q == `RLC_CMP_MODE_OFS) begin
        cmp_mode_q <= w_data_q[2:0];
      end
      if (aw_addr_q == `RLC_PORT_DIR_OFS) begin
        port_dir_q <= w_data_q[7:0];
      end
    end
  end

  // Read channel: one read in flight, answer registered on the acceptance edge
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `RLC_CTRL_OFS:     rd_data = {24'h000000, ctrl_q};
      `RLC_CMP_MODE_OFS: rd_data = {29'h00000000, cmp_mode_q};
      `RLC_PORT_DIR_OFS: rd_data = {24'h000000, port_dir_q};
      `RLC_STATUS_OFS:   rd_data = {24'h000000, level_denom[5:0],
                                    lad_q.cmp_feed, lad_q.pin_connect};
      default:           rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RLC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? RLC_RESP_OKAY : RLC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  rlc_level_calc u_level (
    .range_sel   (ctrl_q.range_sel),
    .tap_code    (ctrl_q.tap_code),
    .level_numer (level_numer),
    .level_denom (level_denom)
  );

  rlc_pin_mux u_pin (
    .pin_drive      (ctrl_q.pin_drive),
    .dir_bit        (port_dir_q[`RLC_PIN_TWO]),
    .analog_connect (pin_connect_d),
    .digital_oe     (pin_oe_d)
  );

  // Ladder controls are registered copies, so they move only after a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lad_q    <= '0;
      pin_oe_q <= 1'b0;
    end else begin
      lad_q.power_on    <= ctrl_q.power_on;
      lad_q.range_sel   <= ctrl_q.range_sel;
      lad_q.supply_sel  <= ctrl_q.supply_sel;
      lad_q.tap_code    <= ctrl_q.tap_code;
      lad_q.pin_connect <= pin_connect_d;
      // Powered-off ladder still reported as selected; mode gates feed only
      lad_q.cmp_feed    <= (cmp_mode_q == `RLC_MUX_MODE);
      pin_oe_q          <= pin_oe_d;
    end
  end

  // Comparator mode gates only the comparator feed, never the ladder itself
  assign ladder_power_on       = lad_q.power_on;
  assign ladder_range_select   = lad_q.range_sel;
  assign ladder_supply_select  = lad_q.supply_sel;
  assign ladder_tap_code       = lad_q.tap_code;
  assign ladder_to_comparators = lad_q.cmp_feed;
  assign ref_pin_connect       = lad_q.pin_connect;
  assign pin_two_digital_oe    = pin_oe_q;

  // Software is expected to clear power before sleep; nothing enforces it

  chk_power_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ladder_power_on == $past(ctrl_q.power_on))
    else $error("ladder power does not follow control bit");
  chk_pin_route: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ref_pin_connect == $past(ctrl_q.pin_drive))
    else $error("pin route does not follow drive bit");
  chk_dir_override: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_pin_connect |-> !pin_two_digital_oe)
    else $error("digital driver active while ladder drives pin");
  chk_range_div: assert property (@(posedge aclk) disable iff (!aresetn)
    level_denom == (ctrl_q.range_sel ? 8'h18 : 8'h20))
    else $error("wrong step divisor for range");
  chk_supply_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ladder_supply_select == $past(ctrl_q.supply_sel))
    else $error("supply select not following control");
  chk_level_eq: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q.range_sel |-> level_numer == 8'h08 + {4'h0, ctrl_q.tap_code})
    else $error("high range numerator wrong");
  chk_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> ctrl_q == 8'h00 && !ladder_power_on && !ref_pin_connect)
    else $error("reset did not clear controls");
  chk_steady_tap: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(ctrl_q) && $past(aresetn)) |-> $past(wr_fire))
    else $error("control changed without a write");
  chk_cmp_feed: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ladder_to_comparators == ($past(cmp_mode_q) == 3'h6))
    else $error("comparator feed outside mux mode");
  chk_indep_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.power_on && cmp_mode_q == 3'h7) |=> ladder_power_on)
    else $error("ladder blocked by comparator mode");
  chk_tap_span: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ladder_tap_code == $past(ctrl_q.tap_code))
    else $error("tap code not passed on");
  chk_range_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ladder_range_select == $past(ctrl_q.range_sel))
    else $error("range select not following control");
  chk_level_low: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.range_sel |-> level_numer == {4'h0, ctrl_q.tap_code})
    else $error("low range numerator wrong");
  chk_oe_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pin_two_digital_oe == $past(!ctrl_q.pin_drive && !port_dir_q[`RLC_PIN_TWO]))
    else $error("digital enable not cut by drive bit");
  chk_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_q == `RLC_CTRL_OFS) |=> s_axi_bvalid && s_axi_bresp == RLC_RESP_OKAY)
    else $error("control write not answered okay");
  chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !addr_known(aw_addr_q)) |=> s_axi_bresp == RLC_RESP_SLVERR)
    else $error("unmapped write not refused");

  // Handshake checks: a pending answer stands, a held item blocks its channel
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_aw_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_held_q |-> !s_axi_awready)
    else $error("write address ready while one is held");
  chk_w_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    w_held_q |-> !s_axi_wready)
    else $error("write data ready while one is held");
  chk_ar_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while a read is pending");

  cov_write_ctrl: cover property (@(posedge aclk) wr_fire && aw_addr_q == `RLC_CTRL_OFS);
  cov_pin_drive:  cover property (@(posedge aclk) ref_pin_connect && ladder_power_on);
  cov_low_range:  cover property (@(posedge aclk) ladder_range_select && ladder_tap_code == 4'hf);
  cov_cmp_feed:   cover property (@(posedge aclk) ladder_to_comparators);
  cov_refused:    cover property (@(posedge aclk) s_axi_bvalid && s_axi_bresp == RLC_RESP_SLVERR);
endmodule

// ==== pkg/rlc_consts.svh ====
// Register offsets, field positions and reset values for the ladder control block
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH
`define RLC_CTRL_OFS        12'h000
`define RLC_CMP_MODE_OFS    12'h004
`define RLC_PORT_DIR_OFS    12'h008
`define RLC_STATUS_OFS      12'h00c
`define RLC_POWER_BIT       7
`define RLC_PIN_DRIVE_BIT   6
`define RLC_RANGE_BIT       5
`define RLC_SUPPLY_BIT      4
`define RLC_CTRL_RESET      8'h00
`define RLC_CMP_MODE_RESET  3'h7
`define RLC_PORT_DIR_RESET  8'hff
`define RLC_MUX_MODE        3'h6
`define RLC_PIN_TWO         2
`define RLC_LOW_DIV         8'h18
`define RLC_HIGH_DIV        8'h20
`define RLC_HIGH_BASE       8'h08
`endif

// ==== pkg/rlc_pkg.sv ====
// Types shared by the ladder control block
package rlc_pkg;
  typedef struct packed {
    logic       power_on;
    logic       pin_drive;
    logic       range_sel;
    logic       supply_sel;
    logic [3:0] tap_code;
  } rlc_ctrl_t;

  typedef struct packed {
    logic       power_on;
    logic       range_sel;
    logic       supply_sel;
    logic [3:0] tap_code;
    logic       pin_connect;
    logic       cmp_feed;
  } rlc_ladder_t;

  typedef enum logic [1:0] {
    RLC_RESP_OKAY   = 2'b00,
    RLC_RESP_SLVERR = 2'b10
  } rlc_resp_t;
endpackage

// ==== sim/tb.sv ====
// Self-checking testbench for the reference ladder control block
`timescale 1ns/10ps
`include "rlc_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb import rlc_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, tap;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pwr, rng, sup, cmpf, pconn, doe;
  int          miscompares, total_checks;

  rlc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .ladder_power_on(pwr), .ladder_range_select(rng),
    .ladder_supply_select(sup), .ladder_tap_code(tap), .ladder_to_comparators(cmpf),
    .ref_pin_connect(pconn), .pin_two_digital_oe(doe)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic results;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded waits: a hung handshake ends the run with a failure
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask

  // Outputs follow the register one edge after the write lands
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic t_reset;
    `CHK({pwr, rng, sup, tap, cmpf, pconn, doe}, 10'h000)
    rdr(`RLC_CTRL_OFS, rd, rs);
    `CHK(rd, 32'h0)
    rdr(`RLC_CMP_MODE_OFS, rd, rs);
    `CHK(rd, {29'h0, `RLC_CMP_MODE_RESET})
    $display("Test reset done");
  endtask

  task automatic t_fields;
    logic [7:0] v [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0f, 8'hff, 8'h3a};
    int i;
    for (i = 0; i < 7; i++) begin
      wr(`RLC_CTRL_OFS, {24'h0, v[i]}, 4'h1, rs);
      settle();
      `CHK(pwr, v[i][7])
      `CHK(pconn, v[i][6])
      `CHK(rng, v[i][5])
      `CHK(sup, v[i][4])
      `CHK(tap, v[i][3:0])
      rdr(`RLC_CTRL_OFS, rd, rs);
      `CHK(rd, {24'h0, v[i]})
      rdr(`RLC_STATUS_OFS, rd, rs);
      `CHK(rd[7:0], {(v[i][5] ? 6'h18 : 6'h20), 1'b0, v[i][6]})
    end
    $display("Test fields done");
  endtask

  task automatic t_pin;
    logic [7:0] dv [3] = '{8'hff, 8'hfb, 8'h04};
    int i, j;
    for (i = 0; i < 3; i++) begin
      for (j = 0; j < 2; j++) begin
        wr(`RLC_PORT_DIR_OFS, {24'h0, dv[i]}, 4'h1, rs);
        wr(`RLC_CTRL_OFS, {24'h0, 1'b1, j[0], 6'h05}, 4'h1, rs);
        settle();
        `CHK(doe, !j[0] && !dv[i][2])
        `CHK(pconn, j[0])
      end
    end
    $display("Test pin done");
  endtask

  task automatic t_mode;
    int m;
    wr(`RLC_CTRL_OFS, 32'h000000c5, 4'h1, rs);
    for (m = 0; m < 8; m++) begin
      wr(`RLC_CMP_MODE_OFS, m, 4'h1, rs);
      settle();
      `CHK(cmpf, m == 6)
      `CHK({pwr, pconn, tap}, 6'h35)
      rdr(`RLC_STATUS_OFS, rd, rs);
      `CHK(rd[1], m == 6)
    end
    $display("Test mode done");
  endtask

  task automatic t_refuse;
    wr(12'h010, 32'h000000ff, 4'hf, rs);
    `CHK(rs, RLC_RESP_SLVERR)
    rdr(12'h010, rd, rs);
    `CHK({rs, rd}, {RLC_RESP_SLVERR, 32'h0})
    wr(`RLC_CTRL_OFS, 32'h000000ff, 4'h0, rs);
    `CHK(rs, RLC_RESP_OKAY)
    rdr(`RLC_CTRL_OFS, rd, rs);
    `CHK(rd, 32'h000000c5)
    // Power cleared before an idle stretch that stands in for sleep
    wr(`RLC_CTRL_OFS, 32'h00000055, 4'h1, rs);
    repeat (40) @(posedge aclk);
    rdr(`RLC_CTRL_OFS, rd, rs);
    `CHK(rd, 32'h00000055)
    `CHK({pwr, pconn, rng, sup, tap}, 8'h55)
    // Reset in mid-run must clear every control output again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK({pwr, pconn, rng, sup, tap, cmpf, doe}, 10'h000)
    rdr(`RLC_CTRL_OFS, rd, rs);
    `CHK(rd, 32'h0)
    $display("Test refuse done");
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_pin();
    t_mode();
    t_refuse();
    results();
  end
endmodule
